// [verilog/fpga_host_config_local_bus.sv]
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// - address/data lines are latched during address strobe as the data-phase address.
// - while loading from the host, a write to any address of either region is configuration data.
// - bridge output drives active-low clear; bridge input reads configuration-complete.
// - strap high at power-up or board reset loads the image from serial flash.
// - once configured, a clear pulse restarts loading from the host, whatever the strap.
// - one on-card clock serves both system logic and local-bus interface.
// - decoder serves a 256 byte I/O space and a 64K byte memory space.
// - fault lamp shows the clear state before completion, software control afterwards.
// - user I/O stays undriven, left to pull-ups, until configuration completes.
module fpga_host_config_local_bus #(
    parameter int               USER_W      = 8,
    parameter int               FIFO_DEPTH  = cfg_loader_pkg::FIFO_DEPTH,
    parameter logic [23:0]      IMAGE_BYTES = cfg_loader_pkg::IMAGE_BYTES_DEF
) (
    // clock, reset, enable
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    // local bus from the bridge
    input  wire logic [cfg_loader_pkg::LB_W-1:0] muxed_addr_data,
    input  wire logic                        addr_strobe,
    input  wire logic                        lb_data_phase,
    input  wire logic                        lb_write,
    input  wire logic                        lb_space,
    output logic                             lb_ready,
    // configuration control pins
    input  wire logic                        bridge_output_pin_n,
    output logic                             bridge_input_pin,
    input  wire logic                        boot_source_select,
    // serial flash
    output logic                             flash_sck,
    output logic                             flash_cs_n,
    output logic                             flash_mosi,
    input  wire logic                        flash_miso,
    // configuration byte sink
    output logic [cfg_loader_pkg::BYTE_W-1:0] cfg_byte,
    output logic                             cfg_byte_valid,
    input  wire logic                        cfg_byte_ready,
    // user pins and lamp
    output logic [USER_W-1:0]                user_io_o,
    output logic [USER_W-1:0]                user_io_oe,
    output logic                             fault_lamp,
    // register port
    input  wire logic [cfg_loader_pkg::REG_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [31:0]                      reg_rdata
);
    localparam int BW = cfg_loader_pkg::BYTE_W;
    localparam int CW = cfg_loader_pkg::CNT_W;

    cfg_loader_pkg::load_state_t  st_q, st_d;
    cfg_loader_pkg::flash_phase_t fph_q, fph_d;

    logic                  rs1_q, rs2_q;
    logic                  srst_n;
    logic [cfg_loader_pkg::PIN_W-1:0] ps1_q, ps2_q;
    logic [cfg_loader_pkg::LB_W-1:0]  lad_s;
    logic                  ads_s, dph_s, wr_s, space_s, clr_n_s, strap_s, miso_s;

    logic [31:0]           addr_q, addr_d;
    logic                  hit, dph_prev_q, wr_start;
    logic                  pend_q, pend_d;
    logic [BW-1:0]         pbyte_q, pbyte_d;

    logic [1:0]            boot_q, boot_d;
    logic                  src_q, src_d, done_q, done_d;
    logic [CW-1:0]         cnt_q, cnt_d;

    logic [7:0]            div_q, div_d;
    logic                  sck_q, sck_d, cs_n_q, cs_n_d, tick;
    logic [4:0]            bit_q, bit_d;
    logic [31:0]           sh_q, sh_d;
    logic [BW-1:0]         in_q, in_d, fbyte_q, fbyte_d;
    logic                  fv_q, fv_d;
    logic [CW-1:0]         rd_q, rd_d;

    logic                  fi_valid, fi_ready, fo_valid, fo_ready, loading;
    logic [BW-1:0]         fi_data;

    logic                  lamp_q, lamp_d;
    logic [USER_W-1:0]     uo_q, uo_d, uoe_q, uoe_d;
    logic [31:0]           rdata_q, rdata_d;

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end
        else
        begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    assign srst_n = rs2_q;

    // all bridge and flash inputs cross in one two-stage bank, so strobe and
    // data keep the same latency relative to each other
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            ps1_q <= '0;
            ps2_q <= '0;
        end
        else if (ce)
        begin
            ps1_q <= {muxed_addr_data, addr_strobe, lb_data_phase, lb_write, lb_space,
                      bridge_output_pin_n, boot_source_select, flash_miso};
            ps2_q <= ps1_q;
        end
    end
    assign {lad_s, ads_s, dph_s, wr_s, space_s, clr_n_s, strap_s, miso_s} = ps2_q;

    // local bus: address latch, decode, one byte per write data phase
    assign hit      = (space_s == cfg_loader_pkg::SPACE_IO)
                      ? (addr_q < cfg_loader_pkg::SPACE0_BYTES)
                      : (addr_q < cfg_loader_pkg::SPACE1_BYTES);
    assign wr_start = dph_s & ~dph_prev_q & wr_s & ~ads_s & hit;
    assign lb_ready = ~pend_q;

    always_comb
    begin
        addr_d  = ads_s ? lad_s : addr_q;
        pend_d  = pend_q;
        pbyte_d = pbyte_q;
        if (pend_q && fi_ready && st_q == cfg_loader_pkg::S_HOST)
            pend_d = 1'b0;
        if (wr_start && !pend_q && st_q == cfg_loader_pkg::S_HOST)
        begin
            pend_d  = 1'b1;
            pbyte_d = lad_s[BW-1:0];
        end
        if (st_q != cfg_loader_pkg::S_HOST)
            pend_d = 1'b0;
    end

    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            addr_q     <= '0;
            dph_prev_q <= 1'b0;
            pend_q     <= 1'b0;
            pbyte_q    <= '0;
        end
        else if (ce)
        begin
            addr_q     <= addr_d;
            dph_prev_q <= dph_s;
            pend_q     <= pend_d;
            pbyte_q    <= pbyte_d;
        end
    end

    // load sequencing
    assign loading  = (st_q == cfg_loader_pkg::S_FLASH) || (st_q == cfg_loader_pkg::S_HOST);
    assign fo_ready = cfg_byte_ready & loading;
    assign cfg_byte_valid = fo_valid & loading;

    always_comb
    begin
        st_d   = st_q;
        boot_d = boot_q;
        src_d  = src_q;
        cnt_d  = cnt_q;
        if (fo_valid && fo_ready)
            cnt_d = cnt_q + 1'b1;
        case (st_q)
            cfg_loader_pkg::S_CLEAR:
            begin
                cnt_d = '0;
                if (boot_q != cfg_loader_pkg::BOOT_WAIT)
                    boot_d = boot_q + 1'b1;
                else if (boot_q == cfg_loader_pkg::BOOT_WAIT && clr_n_s)
                begin
                    // strap only counts at board reset; later clears go to host
                    st_d   = (strap_s && !src_q) ? cfg_loader_pkg::S_FLASH
                                                 : cfg_loader_pkg::S_HOST;
                    src_d  = 1'b1;
                end
            end
            cfg_loader_pkg::S_FLASH,
            cfg_loader_pkg::S_HOST:
            begin
                if (cnt_q == IMAGE_BYTES)
                    st_d = cfg_loader_pkg::S_DONE;
            end
            cfg_loader_pkg::S_DONE:
                st_d = cfg_loader_pkg::S_DONE;
            default:
                st_d = cfg_loader_pkg::S_CLEAR;
        endcase
        if (!clr_n_s && boot_q == cfg_loader_pkg::BOOT_WAIT)
            st_d = cfg_loader_pkg::S_CLEAR;
        done_d = (st_d == cfg_loader_pkg::S_DONE);
    end

    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            st_q   <= cfg_loader_pkg::S_CLEAR;
            boot_q <= '0;
            src_q  <= 1'b0;
            done_q <= 1'b0;
            cnt_q  <= '0;
        end
        else if (ce)
        begin
            st_q   <= st_d;
            boot_q <= boot_d;
            src_q  <= src_d;
            done_q <= done_d;
            cnt_q  <= cnt_d;
        end
    end
    assign bridge_input_pin = done_q;

    // serial flash reader, mode 0; sampling just before the falling edge
    // leaves room for the two-flop delay on the return line
    assign tick = (div_q == 8'(cfg_loader_pkg::SCK_HALF_CYC - 1)) & ~fv_q;

    always_comb
    begin
        fph_d   = fph_q;
        div_d   = fv_q ? div_q : (tick ? '0 : div_q + 1'b1);
        sck_d   = sck_q;
        cs_n_d  = cs_n_q;
        bit_d   = bit_q;
        sh_d    = sh_q;
        in_d    = in_q;
        fbyte_d = fbyte_q;
        fv_d    = fv_q & ~fi_ready;
        rd_d    = rd_q;
        case (fph_q)
            cfg_loader_pkg::F_OFF:
            begin
                div_d = '0;
                if (st_q == cfg_loader_pkg::S_FLASH)
                begin
                    fph_d  = cfg_loader_pkg::F_CMD;
                    cs_n_d = 1'b0;
                    sh_d   = {cfg_loader_pkg::FLASH_READ_CMD, cfg_loader_pkg::FLASH_START_ADDR};
                    bit_d  = '0;
                    rd_d   = '0;
                end
            end
            cfg_loader_pkg::F_CMD,
            cfg_loader_pkg::F_READ:
            begin
                if (tick)
                begin
                    sck_d = ~sck_q;
                    if (sck_q)
                    begin
                        in_d  = {in_q[BW-2:0], miso_s};
                        sh_d  = {sh_q[30:0], 1'b0};
                        bit_d = bit_q + 1'b1;
                        if (fph_q == cfg_loader_pkg::F_CMD
                            && bit_q == cfg_loader_pkg::FLASH_HDR_LAST)
                        begin
                            fph_d = cfg_loader_pkg::F_READ;
                            bit_d = '0;
                        end
                        else if (fph_q == cfg_loader_pkg::F_READ
                                 && bit_q[2:0] == cfg_loader_pkg::FLASH_BYTE_LAST)
                        begin
                            fv_d    = 1'b1;
                            fbyte_d = {in_q[BW-2:0], miso_s};
                            rd_d    = rd_q + 1'b1;
                            if (rd_q + 1'b1 == IMAGE_BYTES)
                            begin
                                fph_d  = cfg_loader_pkg::F_STOP;
                                cs_n_d = 1'b1;
                            end
                        end
                    end
                end
            end
            cfg_loader_pkg::F_STOP:
                div_d = '0;
            default:
                fph_d = cfg_loader_pkg::F_OFF;
        endcase
        if (st_q != cfg_loader_pkg::S_FLASH && fph_q != cfg_loader_pkg::F_OFF)
        begin
            fph_d  = cfg_loader_pkg::F_OFF;
            sck_d  = 1'b0;
            cs_n_d = 1'b1;
            fv_d   = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            fph_q   <= cfg_loader_pkg::F_OFF;
            div_q   <= '0;
            sck_q   <= 1'b0;
            cs_n_q  <= 1'b1;
            bit_q   <= '0;
            sh_q    <= '0;
            in_q    <= '0;
            fbyte_q <= '0;
            fv_q    <= 1'b0;
            rd_q    <= '0;
        end
        else if (ce)
        begin
            fph_q   <= fph_d;
            div_q   <= div_d;
            sck_q   <= sck_d;
            cs_n_q  <= cs_n_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            in_q    <= in_d;
            fbyte_q <= fbyte_d;
            fv_q    <= fv_d;
            rd_q    <= rd_d;
        end
    end
    assign flash_sck  = sck_q;
    assign flash_cs_n = cs_n_q;
    assign flash_mosi = sh_q[31];

    // both sources share one byte queue toward the configuration sink
    assign fi_valid = (st_q == cfg_loader_pkg::S_FLASH) ? fv_q
                    : (st_q == cfg_loader_pkg::S_HOST) ? pend_q : 1'b0;
    assign fi_data  = (st_q == cfg_loader_pkg::S_FLASH) ? fbyte_q : pbyte_q;

    byte_fifo #(
        .WIDTH (BW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (srst_n),
        .ce        (ce),
        .flush     (st_q == cfg_loader_pkg::S_CLEAR),
        .in_valid  (fi_valid),
        .in_ready  (fi_ready),
        .in_data   (fi_data),
        .out_valid (fo_valid),
        .out_ready (fo_ready),
        .out_data  (cfg_byte)
    );

    // register port
    always_comb
    begin
        lamp_d  = lamp_q;
        uo_d    = uo_q;
        uoe_d   = uoe_q;
        rdata_d = '0;
        if (reg_wr)
        begin
            case (reg_addr)
                cfg_loader_pkg::REG_CTRL:     lamp_d = reg_wdata[cfg_loader_pkg::CTRL_LAMP_BIT];
                cfg_loader_pkg::REG_USER_OUT: uo_d   = reg_wdata[USER_W-1:0];
                cfg_loader_pkg::REG_USER_OE:  uoe_d  = reg_wdata[USER_W-1:0];
                default:                      lamp_d = lamp_q;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                cfg_loader_pkg::REG_CTRL:
                    rdata_d[cfg_loader_pkg::CTRL_LAMP_BIT] = lamp_q;
                cfg_loader_pkg::REG_STATUS:
                begin
                    rdata_d[cfg_loader_pkg::STAT_DONE_BIT] = done_q;
                    rdata_d[cfg_loader_pkg::STAT_SRC_BIT]  = strap_s;
                    rdata_d[cfg_loader_pkg::STAT_PEND_BIT] = pend_q;
                    rdata_d[cfg_loader_pkg::STAT_ST_LSB +: 2] = st_q;
                end
                cfg_loader_pkg::REG_COUNT:    rdata_d[CW-1:0]     = cnt_q;
                cfg_loader_pkg::REG_USER_OUT: rdata_d[USER_W-1:0] = uo_q;
                cfg_loader_pkg::REG_USER_OE:  rdata_d[USER_W-1:0] = uoe_q;
                default:                      rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            lamp_q  <= 1'b0;
            uo_q    <= '0;
            uoe_q   <= '0;
            rdata_q <= '0;
        end
        else if (ce)
        begin
            lamp_q  <= lamp_d;
            uo_q    <= uo_d;
            uoe_q   <= uoe_d;
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata  = rdata_q;
    assign user_io_o  = uo_q;
    // undriven pins fall back to the board pull-ups before completion
    assign user_io_oe = done_q ? uoe_q : '0;
    assign fault_lamp = done_q ? lamp_q : (st_q == cfg_loader_pkg::S_CLEAR);

endmodule // fpga_host_config_local_bus

// [pkg/cfg_loader_pkg.sv]
package cfg_loader_pkg;

    // local bus
    localparam int          LB_W          = 32;
    localparam int          BYTE_W        = 8;
    localparam logic [31:0] SPACE0_BYTES  = 32'h0000_0100;
    localparam logic [31:0] SPACE1_BYTES  = 32'h0001_0000;
    localparam logic        SPACE_IO      = 1'b0;

    // pin synchroniser and strap capture
    localparam int          PIN_W         = LB_W + 7;
    localparam logic [1:0]  BOOT_WAIT     = 2'h3;

    // register port
    localparam int          REG_ADDR_W    = 5;
    localparam logic [4:0]  REG_CTRL      = 5'h00;
    localparam logic [4:0]  REG_STATUS    = 5'h04;
    localparam logic [4:0]  REG_COUNT     = 5'h08;
    localparam logic [4:0]  REG_USER_OUT  = 5'h0C;
    localparam logic [4:0]  REG_USER_OE   = 5'h10;
    localparam int          CTRL_LAMP_BIT = 0;
    localparam int          STAT_DONE_BIT = 0;
    localparam int          STAT_SRC_BIT  = 1;
    localparam int          STAT_PEND_BIT = 2;
    localparam int          STAT_ST_LSB   = 4;

    // serial flash read
    localparam logic [7:0]  FLASH_READ_CMD   = 8'h03;
    localparam logic [23:0] FLASH_START_ADDR = 24'h00_0000;
    localparam logic [4:0]  FLASH_HDR_LAST   = 5'h1F;
    localparam logic [2:0]  FLASH_BYTE_LAST  = 3'h7;

    // timing
    localparam int          CLK_NS        = 50;
    localparam int          SCK_HALF_NS   = 100;
    localparam int          SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

    // sizes
    localparam int          CNT_W         = 24;
    localparam int          FIFO_DEPTH    = 32;
    localparam logic [23:0] IMAGE_BYTES_DEF = 24'h10_0000;

    typedef enum logic [1:0] {S_CLEAR, S_FLASH, S_HOST, S_DONE} load_state_t;
    typedef enum logic [1:0] {F_OFF, F_CMD, F_READ, F_STOP} flash_phase_t;

endpackage

// [verilog/byte_fifo.sv]
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, load;

    // the output register is the head; the array holds the rest
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign push      = in_valid & in_ready;
    assign load      = (cnt_q != '0) & (~ov_q | out_ready);
    assign out_valid = ov_q;
    assign out_data  = od_q;

    always_comb
    begin
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        ov_d  = ov_q;
        od_d  = od_q;
        if (push)
            wp_d = (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
        if (load)
        begin
            rp_d = (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            od_d = mem_q[rp_q];
            ov_d = 1'b1;
        end
        else if (out_ready)
            ov_d = 1'b0;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        if (flush)
        begin
            wp_d  = '0;
            rp_d  = '0;
            cnt_d = '0;
            ov_d  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end
        else if (ce)
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    // storage has no reset, so it maps onto plain ram
    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem_q[wp_q] <= in_data;
    end

endmodule // byte_fifo

// [test/cfg_loader_checker.sv]
`timescale 1ns/10ps
module cfg_loader_checker #(
    parameter int USER_W = 8
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // local bus
    input wire logic              addr_strobe,
    input wire logic              lb_data_phase,
    input wire logic              lb_write,
    input wire logic              lb_ready,
    // control pins and sinks
    input wire logic              bridge_output_pin_n,
    input wire logic              bridge_input_pin,
    input wire logic              flash_sck,
    input wire logic              flash_cs_n,
    input wire logic [7:0]        cfg_byte,
    input wire logic              cfg_byte_valid,
    input wire logic              cfg_byte_ready,
    input wire logic [USER_W-1:0] user_io_oe,
    input wire logic              fault_lamp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_oe_before_done: assert property (!bridge_input_pin |-> user_io_oe == '0)
        else $error("user pins driven before completion");
    a_lamp_on_clear: assert property ($fell(bridge_output_pin_n) |-> ##[1:4] fault_lamp)
        else $error("lamp dark after clear");
    a_clear_kills_done: assert property (!bridge_output_pin_n [*4] |-> !bridge_input_pin)
        else $error("complete while clear held");
    a_ready_after_write: assert property ($fell(lb_ready) |->
        $past(lb_data_phase) && $past(lb_write) && !addr_strobe)
        else $error("ready fell without a data phase");
    a_byte_held_stall: assert property (cfg_byte_valid && !cfg_byte_ready |=>
        cfg_byte_valid && $stable(cfg_byte))
        else $error("byte dropped under stall");
    a_done_after_drain: assert property ($rose(bridge_input_pin) |->
        $past(cfg_byte_valid && cfg_byte_ready, 2))
        else $error("complete without a last byte");
    a_flash_off_done: assert property (bridge_input_pin |-> flash_cs_n)
        else $error("flash selected after completion");
    a_ready_when_done: assert property (bridge_input_pin |-> lb_ready)
        else $error("bus stalled after completion");
    a_sck_idle_low: assert property (flash_cs_n |-> !flash_sck)
        else $error("flash clock moving while deselected");

    c_done: cover property ($rose(bridge_input_pin));
    c_taken: cover property ($fell(lb_ready));
    c_flash: cover property ($fell(flash_cs_n));
endmodule // cfg_loader_checker

bind fpga_host_config_local_bus cfg_loader_checker #(.USER_W(USER_W)) cfg_loader_checker_i (
    .clk(clk), .rstn(rstn), .addr_strobe(addr_strobe), .lb_data_phase(lb_data_phase),
    .lb_write(lb_write), .lb_ready(lb_ready), .bridge_output_pin_n(bridge_output_pin_n),
    .bridge_input_pin(bridge_input_pin), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
    .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid), .cfg_byte_ready(cfg_byte_ready),
    .user_io_oe(user_io_oe), .fault_lamp(fault_lamp));

// [test/lb_bridge_model.sv]
`timescale 1ns/10ps
module lb_bridge_model (
    // clock
    input  wire logic   clk,
    // multiplexed bus toward the block
    output logic [31:0] muxed_addr_data,
    output logic        addr_strobe,
    output logic        lb_data_phase,
    output logic        lb_write,
    output logic        lb_space,
    input  wire logic   lb_ready
);
    initial
    begin
        muxed_addr_data = 32'h0000_0000;
        addr_strobe = 1'b0;
        lb_data_phase = 1'b0;
        lb_write = 1'b0;
        lb_space = 1'b0;
    end

    // refused writes never drop ready, so the hold is bounded
    task automatic wr(input logic sp, input logic [31:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        addr_strobe <= 1'b1;
        muxed_addr_data <= adr;
        lb_space <= sp;
        @(posedge clk);
        addr_strobe <= 1'b0;
        @(posedge clk);
        lb_data_phase <= 1'b1;
        lb_write <= 1'b1;
        muxed_addr_data <= dat;
        while (lb_ready === 1'b1 && n < 8)
        begin
            @(posedge clk);
            n++;
        end
        lb_data_phase <= 1'b0;
        lb_write <= 1'b0;
        muxed_addr_data <= ~dat;
        n = 0;
        while (lb_ready !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            n++;
        end
    endtask
endmodule // lb_bridge_model

// [test/fpga_host_config_local_bus_tb.sv]
`timescale 1ns/10ps
module fpga_host_config_local_bus_tb;
    localparam int IMG = 8;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        clr_n = 1'b1;
    logic        strap = 1'b0;
    logic        miso = 1'b0;
    logic        sink_rdy = 1'b0;
    logic        chk_en = 1'b0;
    logic [4:0]  reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] mad, rdata, reg_rdata, seed_v;
    logic        as, dp, wr, sp, rdy, done, sck, cs_n, mosi, cbv, lamp;
    logic [7:0]  cb, uo, uoe;
    logic [7:0]  exp_q[$];
    int          bad_count = 0;
    int          comparisons = 0;

    always #25 clk = ~clk;

    lb_bridge_model lb_bridge_model_i (.clk(clk), .muxed_addr_data(mad), .addr_strobe(as),
        .lb_data_phase(dp), .lb_write(wr), .lb_space(sp), .lb_ready(rdy));

    fpga_host_config_local_bus #(.IMAGE_BYTES(24'h00_0008)) fpga_host_config_local_bus_i (
        .clk(clk), .rstn(rstn), .ce(1'b1), .muxed_addr_data(mad), .addr_strobe(as),
        .lb_data_phase(dp), .lb_write(wr), .lb_space(sp), .lb_ready(rdy),
        .bridge_output_pin_n(clr_n), .bridge_input_pin(done), .boot_source_select(strap),
        .flash_sck(sck), .flash_cs_n(cs_n), .flash_mosi(mosi), .flash_miso(miso),
        .cfg_byte(cb), .cfg_byte_valid(cbv), .cfg_byte_ready(sink_rdy), .user_io_o(uo),
        .user_io_oe(uoe), .fault_lamp(lamp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // far side of the sink stalls at random; flash data changes every cycle
    always @(posedge clk)
    begin
        sink_rdy <= ($urandom % 4) != 0;
        miso <= 1'($urandom);
        if (chk_en && cbv === 1'b1 && sink_rdy === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("spare byte", 32'h1, 32'h0);
            else
                chk("cfg byte", {24'h0, exp_q.pop_front()}, {24'h0, cb});
        end
    end

    task automatic host_load();
        logic [7:0] b;
        int n;
        clr_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("done cleared", 32'h0, {31'h0, done});
        clr_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk_en = 1'b1;
        lb_bridge_model_i.wr(1'b0, 32'h0000_0100, 32'hFFFF_FF5A);
        for (int i = 0; i < IMG; i++)
        begin
            b = 8'($urandom);
            exp_q.push_back(b);
            lb_bridge_model_i.wr(i[0], i[0] ? 32'h0000_FFFC : {24'h0, 8'($urandom)},
                {24'($urandom), b});
        end
        n = 0;
        while (done !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        chk("done", 32'h1, {31'h0, done});
        chk("left bytes", 32'h0, exp_q.size());
    endtask

    initial
    begin
        seed_v = $urandom(32'hC5A8F1E8);
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("oe idle", 32'h0, {24'h0, uoe});
        rd(5'h04, rdata);
        chk("status", 32'h0000_0020, rdata);
        host_load();
        rd(5'h08, rdata);
        chk("count", IMG, rdata);
        lb_bridge_model_i.wr(1'b1, 32'h0000_0010, 32'h0000_0077);
        rw(5'h00, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("lamp on", 32'h1, {31'h0, lamp});
        rw(5'h00, 32'h0000_0000);
        rw(5'h10, 32'h0000_00FF);
        rw(5'h0C, 32'h0000_00A5);
        repeat (2) @(posedge clk);
        chk("lamp off", 32'h0, {31'h0, lamp});
        chk("user oe", 32'hFF, {24'h0, uoe});
        chk("user out", 32'hA5, {24'h0, uo});
        rd(5'h1C, rdata);
        chk("unmapped", 32'h0, rdata);
        chk_en = 1'b0;
        strap <= 1'b1;
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (32) @(posedge clk);
        chk("flash select", 32'h0, {31'h0, cs_n});
        chk("cmd bit", 32'h1, {31'h0, mosi});
        host_load();
        tally_and_finish();
    end

    initial
    begin
        #2000000;
        bad_count++;
        tally_and_finish();
    end
endmodule // fpga_host_config_local_bus_tb
